//--- rtl/vslm_pkg.sv
package vslm_pkg;
  // ********************************************************
  // Operation codes
  // ********************************************************
  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_QUAD   = 4'h1,
    OP_REST   = 4'h2,
    OP_SHORT  = 4'h3,
    OP_TRANS  = 4'h4,
    OP_UPACK  = 4'h5,
    OP_UPPER  = 4'h6,
    OP_WORD   = 4'h7,
    OP_RDCTL  = 4'h8,
    OP_RDVEC  = 4'h9,
    OP_WRCTL  = 4'ha
  } vslm_op_t;

  // ********************************************************
  // Widths and constants
  // ********************************************************
  localparam int          ADDR_W      = 12;
  localparam logic [3:0]  LOAD_DELAY  = 4'h3;
  localparam logic [4:0]  GROUP_MASK  = 5'h18;
  localparam logic [2:0]  SLICE_MASK  = 3'h7;
  localparam logic [4:0]  BYTES_QUAD  = 5'h10;
  localparam int          PACK_MSB    = 14;
  localparam int          TRACK_N     = 4;
endpackage

//--- rtl/vslm_tracker.sv
`timescale 1ns/1ps
// Scoreboard of pending vector load targets and delay counts
module vslm_tracker (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       issueLoad,
  input  wire logic [4:0] issueReg,
  input  wire logic       useValid,
  input  wire logic [4:0] useReg,
  output logic            stall
);
  typedef struct packed {
    logic [vslm_pkg::TRACK_N-1:0]      vld;
    logic [vslm_pkg::TRACK_N-1:0][4:0] reg_;
    logic [vslm_pkg::TRACK_N-1:0][3:0] cnt;
  } vslm_trk_t;

  vslm_trk_t st_r;
  vslm_trk_t st_nxt;
  logic [vslm_pkg::TRACK_N-1:0] hit;

  // ********************************************************
  // Hit detection per entry
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < vslm_pkg::TRACK_N; g++) begin : gHit
      assign hit[g] = st_r.vld[g] && useValid && (st_r.reg_[g] == useReg);
    end
  endgenerate
  assign stall = |hit;

  // Count down, retire, allocate
  always_comb begin
    logic [1:0] slot;
    st_nxt = st_r;
    slot   = '0;
    for (int i = 0; i < vslm_pkg::TRACK_N; i++) begin
      if (st_r.vld[i]) begin
        st_nxt.cnt[i] = st_r.cnt[i] - 4'h1;
        if (st_r.cnt[i] == 4'h1) begin
          st_nxt.vld[i] = 1'b0;
        end
      end
    end
    // Oldest retires before a new load needs a slot; lowest free entry wins
    if (issueLoad) begin
      for (int i = vslm_pkg::TRACK_N - 1; i >= 0; i--) begin
        if (!st_nxt.vld[i]) begin
          slot = 2'(i);
        end
      end
      st_nxt.vld[slot]  = 1'b1;
      st_nxt.reg_[slot] = issueReg;
      st_nxt.cnt[slot]  = vslm_pkg::LOAD_DELAY;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  chk_stall_hit: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issueLoad ##1 (useValid && useReg == $past(issueReg))) |-> stall)
    else $error("dependent use not stalled");
  chk_load_retire: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issueLoad && !stall) ##1 (!issueLoad [*3]) |=> !stall)
    else $error("stall after delay slots");
endmodule

//--- rtl/vslm_unit.sv
`timescale 1ns/1ps
module vslm_unit (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 issueValid,
  input  wire vslm_pkg::vslm_op_t   issueOp,
  input  wire logic [31:0]          baseVal,
  input  wire logic [15:0]          offsetImm,
  input  wire logic [4:0]           vecTarget,
  input  wire logic [3:0]           elemSel,
  input  wire logic [4:0]           gprDest,
  input  wire logic [31:0]          gprSrc,
  input  wire logic [4:0]           ctlSel,
  input  wire logic [31:0]          ctlRdData,
  input  wire logic [127:0]         vecRdData,
  input  wire logic [127:0]         memRdData,
  input  wire logic                 useValid,
  input  wire logic [4:0]           useReg,
  output logic [11:0]               memAddr,
  output logic                      gprWe,
  output logic [4:0]                gprWaddr,
  output logic [31:0]               gprWdata,
  output logic                      ctlWe,
  output logic [4:0]                ctlWaddr,
  output logic [31:0]               ctlWdata,
  output logic [7:0]                vecWe,
  output logic [7:0][4:0]           vecWaddr,
  output logic [7:0][15:0]          vecWmask,
  output logic [7:0][127:0]         vecWdata,
  output logic                      stallOut
);
  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [11:0]        memAddr;
    logic               gprWe;
    logic [4:0]         gprWaddr;
    logic [31:0]        gprWdata;
    logic               ctlWe;
    logic [4:0]         ctlWaddr;
    logic [31:0]        ctlWdata;
    logic [7:0]         vecWe;
    logic [7:0][4:0]    vecWaddr;
    logic [7:0][15:0]   vecWmask;
    logic [7:0][127:0]  vecWdata;
    logic               stall;
  } vslm_st_t;

  vslm_st_t st_r;
  vslm_st_t st_nxt;
  logic     stallNow;
  logic     isVecLoad;
  logic [31:0] sxOff;
  logic [31:0] effAddr;
  logic [3:0]  lowBits;
  logic [7:0]  memByte [16];

  // ********************************************************
  // Address forming
  // ********************************************************
  assign sxOff   = {{16{offsetImm[15]}}, offsetImm};
  always_comb begin
    if (issueOp == vslm_pkg::OP_SHORT) begin
      effAddr = baseVal + {sxOff[30:0], 1'b0};
    end else begin
      effAddr = baseVal + sxOff;
    end
  end
  assign lowBits = effAddr[3:0];

  assign isVecLoad = issueValid && (issueOp inside {vslm_pkg::OP_QUAD, vslm_pkg::OP_REST,
                     vslm_pkg::OP_SHORT, vslm_pkg::OP_TRANS, vslm_pkg::OP_UPACK});

  // Byte view of the memory line, byte 0 at the top
  genvar b;
  generate
    for (b = 0; b < 16; b++) begin : gByte
      assign memByte[b] = memRdData[127 - 8*b -: 8];
    end
  endgenerate

  vslm_tracker vslm_tracker_i (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .issueLoad (isVecLoad && !stallNow),
    .issueReg  (vecTarget),
    .useValid  (useValid),
    .useReg    (useReg),
    .stall     (stallNow)
  );

  // ********************************************************
  // Execute one instruction per cycle
  // ********************************************************
  always_comb begin
    logic [3:0]  dr;
    logic [15:0] half;
    st_nxt          = '0;
    dr              = '0;
    half            = '0;
    st_nxt.stall    = stallNow;
    st_nxt.memAddr  = effAddr[vslm_pkg::ADDR_W-1:0];
    st_nxt.vecWaddr[0] = vecTarget;
    if (issueValid && !stallNow) begin
      unique case (issueOp)
        vslm_pkg::OP_QUAD: begin
          for (int i = 0; i < 16; i++) begin
            if (5'(i) < vslm_pkg::BYTES_QUAD - 5'(lowBits)) begin
              st_nxt.vecWmask[0][i] = 1'b1;
              st_nxt.vecWdata[0][127 - 8*i -: 8] = memByte[i + lowBits];
            end
          end
          st_nxt.vecWe[0] = 1'b1;
        end
        vslm_pkg::OP_REST: begin
          for (int i = 0; i < 16; i++) begin
            if (lowBits != 4'h0 && 5'(i) >= vslm_pkg::BYTES_QUAD - 5'(lowBits)) begin
              st_nxt.vecWmask[0][i] = 1'b1;
              st_nxt.vecWdata[0][127 - 8*i -: 8] = memByte[4'(i) + lowBits];
            end
          end
          st_nxt.vecWe[0] = (lowBits != 4'h0);
        end
        vslm_pkg::OP_SHORT: begin
          dr = elemSel;
          st_nxt.vecWmask[0][dr] = 1'b1;
          st_nxt.vecWmask[0][dr + 4'h1] = 1'b1;
          st_nxt.vecWdata[0][127 - 8*dr -: 8] = memByte[lowBits];
          st_nxt.vecWdata[0][127 - 8*(dr + 4'h1) -: 8] = memByte[lowBits + 4'h1];
          st_nxt.vecWe[0] = 1'b1;
        end
        vslm_pkg::OP_TRANS: begin
          for (int s = 0; s < 8; s++) begin
            st_nxt.vecWe[s]    = 1'b1;
            st_nxt.vecWaddr[s] = (vecTarget & vslm_pkg::GROUP_MASK) |
                                 {2'b00, (3'(s) + elemSel[3:1]) & vslm_pkg::SLICE_MASK};
            st_nxt.vecWmask[s][2*s]     = 1'b1;
            st_nxt.vecWmask[s][2*s + 1] = 1'b1;
            st_nxt.vecWdata[s][127 - 16*s -: 16] = memRdData[127 - 16*s -: 16];
          end
        end
        vslm_pkg::OP_UPACK: begin
          for (int i = 0; i < 8; i++) begin
            half = {1'b0, memByte[4'(i) + lowBits], 7'h00};
            st_nxt.vecWdata[0][127 - 16*i -: 16] = half;
            st_nxt.vecWmask[0][2*i]     = 1'b1;
            st_nxt.vecWmask[0][2*i + 1] = 1'b1;
          end
          st_nxt.vecWe[0] = 1'b1;
        end
        vslm_pkg::OP_UPPER: begin
          st_nxt.gprWe    = 1'b1;
          st_nxt.gprWaddr = gprDest;
          st_nxt.gprWdata = {offsetImm, 16'h0000};
        end
        vslm_pkg::OP_WORD: begin
          st_nxt.gprWe    = 1'b1;
          st_nxt.gprWaddr = gprDest;
          st_nxt.gprWdata = {memByte[lowBits], memByte[lowBits + 4'h1],
                             memByte[lowBits + 4'h2], memByte[lowBits + 4'h3]};
        end
        vslm_pkg::OP_RDCTL: begin
          st_nxt.gprWe    = 1'b1;
          st_nxt.gprWaddr = gprDest;
          st_nxt.gprWdata = ctlRdData;
        end
        vslm_pkg::OP_RDVEC: begin
          half = vecRdData[127 - 8*elemSel -: 16];
          st_nxt.gprWe    = 1'b1;
          st_nxt.gprWaddr = gprDest;
          st_nxt.gprWdata = {{16{half[15]}}, half};
        end
        vslm_pkg::OP_WRCTL: begin
          st_nxt.ctlWe    = 1'b1;
          st_nxt.ctlWaddr = ctlSel;
          st_nxt.ctlWdata = gprSrc;
        end
        default: begin
          st_nxt.gprWe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign memAddr  = st_r.memAddr;
  assign gprWe    = st_r.gprWe;
  assign gprWaddr = st_r.gprWaddr;
  assign gprWdata = st_r.gprWdata;
  assign ctlWe    = st_r.ctlWe;
  assign ctlWaddr = st_r.ctlWaddr;
  assign ctlWdata = st_r.ctlWdata;
  assign vecWe    = st_r.vecWe;
  assign vecWaddr = st_r.vecWaddr;
  assign vecWmask = st_r.vecWmask;
  assign vecWdata = st_r.vecWdata;
  assign stallOut = st_r.stall;

  // ********************************************************
  // Checks
  // ********************************************************
  chk_upper_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issueValid && !stallNow && issueOp == vslm_pkg::OP_UPPER) |=>
      (gprWe && gprWdata == {$past(offsetImm), 16'h0000}))
    else $error("upper immediate wrong");
  chk_ctl_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issueValid && !stallNow && issueOp == vslm_pkg::OP_WRCTL) |=>
      (ctlWe && ctlWdata == $past(gprSrc) && ctlWaddr == $past(ctlSel)))
    else $error("control write wrong");
  chk_ctl_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issueValid && !stallNow && issueOp == vslm_pkg::OP_RDCTL) |=>
      (gprWe && gprWdata == $past(ctlRdData)))
    else $error("control read wrong");
  chk_vec_sext: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issueValid && !stallNow && issueOp == vslm_pkg::OP_RDVEC) |=>
      (gprWe && gprWaddr == $past(gprDest) && gprWdata[31:16] == {16{gprWdata[15]}}))
    else $error("vector read not sign extended");
  chk_rest_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issueValid && !stallNow && issueOp == vslm_pkg::OP_REST && lowBits == 4'h0) |=>
      (vecWe == 8'h00))
    else $error("empty rest load wrote");
  chk_rest_mask: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issueValid && !stallNow && issueOp == vslm_pkg::OP_REST && lowBits == 4'h4) |=>
      (vecWmask[0] == 16'hf000))
    else $error("rest mask wrong");
  chk_trans_all: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issueValid && !stallNow && issueOp == vslm_pkg::OP_TRANS) |=>
      (vecWe == 8'hff && vecWaddr[0][4:3] == $past(vecTarget[4:3])))
    else $error("transpose group wrong");
  chk_word_addr: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issueValid && issueOp == vslm_pkg::OP_WORD) |=>
      (memAddr == 12'($past(baseVal) + {{16{$past(offsetImm[15])}}, $past(offsetImm)})))
    else $error("word address wrong");
endmodule

//--- tb/vector_scalar_load_move_unit_tb.sv
`timescale 1ns/1ps
module vector_scalar_load_move_unit_tb;
  // ****************************************
  // Signals, clock and instances
  // ****************************************
  logic               ref_clk = 1'b0, rstn = 1'b0, issueValid = 1'b0, useValid = 1'b0;
  vslm_pkg::vslm_op_t issueOp = vslm_pkg::OP_NONE;
  logic [31:0]        baseVal = 32'h0, gprSrc = 32'h0;
  logic [15:0]        offsetImm = 16'h0;
  logic [4:0]         vecTarget = 5'h0, gprDest = 5'h0, ctlSel = 5'h0, useReg = 5'h0;
  logic [3:0]         elemSel = 4'h0;
  logic [11:0]        eaIn = 12'h0, memAddr;
  logic [31:0]        gprWdata, ctlWdata, ctlRdData;
  logic [4:0]         gprWaddr, ctlWaddr;
  logic               gprWe, ctlWe, stallOut;
  logic [127:0]       vecRdData, memRdData;
  logic [7:0]         vecWe;
  logic [7:0][4:0]    vecWaddr;
  logic [7:0][15:0]   vecWmask;
  logic [7:0][127:0]  vecWdata;
  int                 num_errors = 0, check_count = 0, cycles = 0;

  // Free-running clock
  always #12.5 ref_clk = ~ref_clk;

  vslm_unit vslm_unit_i (
    .ref_clk(ref_clk), .rstn(rstn), .issueValid(issueValid), .issueOp(issueOp),
    .baseVal(baseVal), .offsetImm(offsetImm), .vecTarget(vecTarget), .elemSel(elemSel),
    .gprDest(gprDest), .gprSrc(gprSrc), .ctlSel(ctlSel), .ctlRdData(ctlRdData),
    .vecRdData(vecRdData), .memRdData(memRdData), .useValid(useValid), .useReg(useReg),
    .memAddr(memAddr), .gprWe(gprWe), .gprWaddr(gprWaddr), .gprWdata(gprWdata),
    .ctlWe(ctlWe), .ctlWaddr(ctlWaddr), .ctlWdata(ctlWdata), .vecWe(vecWe),
    .vecWaddr(vecWaddr), .vecWmask(vecWmask), .vecWdata(vecWdata), .stallOut(stallOut)
  );
  vslm_mem_model vslm_mem_model_i (
    .ref_clk(ref_clk), .addr(eaIn), .ctlSel(ctlSel), .vecSel(vecTarget), .ctlWe(ctlWe),
    .ctlWaddr(ctlWaddr), .ctlWdata(ctlWdata), .memLine(memRdData), .ctlData(ctlRdData),
    .vecData(vecRdData)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // Bench copy of the memory byte pattern
  function automatic logic [7:0] mb(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  function automatic logic [7:0] vby(input int s, input int j);
    return vecWdata[s][127-8*j -: 8];
  endfunction

  // Drive one instruction, let it be taken, then sample its strobes
  task automatic go(input vslm_pkg::vslm_op_t op, input logic [31:0] b, input logic [15:0] o,
                    input logic [4:0] vt, input logic [3:0] el, input logic [4:0] rd,
                    input logic [4:0] cs, input logic [31:0] gs);
    @(posedge ref_clk);
    issueOp <= op;
    baseVal <= b;
    offsetImm <= o;
    vecTarget <= vt;
    elemSel <= el;
    gprDest <= rd;
    ctlSel <= cs;
    gprSrc <= gs;
    eaIn <= b[11:0] + ((op == vslm_pkg::OP_SHORT) ? {o[10:0], 1'b0} : o[11:0]);
    issueValid <= 1'b1;
    @(posedge ref_clk);
    issueValid <= 1'b0;
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_scalar;
    go(vslm_pkg::OP_UPPER, 32'h0, 16'h1234, 5'h0, 4'h0, 5'h03, 5'h0, 32'h0);
    chk(gprWe === 1'b1 && gprWaddr === 5'h03 && gprWdata === 32'h12340000, "upper");
    go(vslm_pkg::OP_WORD, 32'h10000124, 16'hfff0, 5'h0, 4'h0, 5'h09, 5'h0, 32'h0);
    chk(memAddr === 12'h114 && gprWaddr === 5'h09, "word address");
    chk(gprWdata === {mb(12'h114), mb(12'h115), mb(12'h116), mb(12'h117)}, "word");
    $display("test scalar done");
  endtask

  task automatic t_ctl;
    go(vslm_pkg::OP_RDCTL, 32'h0, 16'h0, 5'h0, 4'h0, 5'h07, 5'h05, 32'h0);
    chk(gprWe === 1'b1 && gprWaddr === 5'h07 && gprWdata === 32'hc0de0005, "ctl read");
    go(vslm_pkg::OP_WRCTL, 32'h0, 16'h0, 5'h0, 4'h0, 5'h07, 5'h0c, 32'hdeadbeef);
    chk(ctlWe === 1'b1 && ctlWaddr === 5'h0c && ctlWdata === 32'hdeadbeef, "ctl write");
    go(vslm_pkg::OP_RDCTL, 32'h0, 16'h0, 5'h0, 4'h0, 5'h07, 5'h0c, 32'h0);
    chk(gprWdata === 32'hdeadbeef, "ctl readback");
    go(vslm_pkg::OP_RDVEC, 32'h0, 16'h0, 5'h02, 4'h3, 5'h0a, 5'h0, 32'h0);
    chk(gprWaddr === 5'h0a && gprWdata === 32'hffffa3a4, "vec read");
    $display("test ctl done");
  endtask

  task automatic t_quad;
    go(vslm_pkg::OP_QUAD, 32'h200, 16'h0034, 5'h02, 4'h0, 5'h0, 5'h0, 32'h0);
    chk(memAddr === 12'h234 && vecWe[0] === 1'b1 && vecWaddr[0] === 5'h02, "quad");
    chk(vecWmask[0] === 16'h0fff, "quad mask");
    for (int j = 0; j < 12; j++) chk(vby(0, j) === mb(12'h234 + 12'(j)), "quad byte");
    go(vslm_pkg::OP_REST, 32'h200, 16'h0034, 5'h03, 4'h0, 5'h0, 5'h0, 32'h0);
    chk(vecWaddr[0] === 5'h03 && vecWmask[0] === 16'hf000, "rest mask");
    for (int k = 0; k < 4; k++) chk(vby(0, 12 + k) === mb(12'h230 + 12'(k)), "rest");
    go(vslm_pkg::OP_REST, 32'h200, 16'h0040, 5'h03, 4'h0, 5'h0, 5'h0, 32'h0);
    chk(vecWe === 8'h0 && vecWmask[0] === 16'h0, "rest empty");
    $display("test quad done");
  endtask

  task automatic t_slices;
    // Source offset 6 goes in halved
    go(vslm_pkg::OP_SHORT, 32'h300, 16'h0003, 5'h04, 4'h4, 5'h0, 5'h0, 32'h0);
    chk(memAddr === 12'h306 && vecWmask[0] === 16'h0030, "short mask");
    chk(vby(0, 4) === mb(12'h306) && vby(0, 5) === mb(12'h307), "short");
    go(vslm_pkg::OP_TRANS, 32'h400, 16'h0, 5'h0b, 4'h6, 5'h0, 5'h0, 32'h0);
    for (int s = 0; s < 8; s++) begin
      chk(vecWe[s] === 1'b1 && vecWaddr[s] === (5'h08 | 5'((s + 3) % 8)), "trans reg");
      chk(vecWmask[s] === (16'h3 << (2 * s)), "trans mask");
      chk({vby(s, 2 * s), vby(s, 2 * s + 1)} === {mb(12'h400 + 12'(2 * s)),
          mb(12'h401 + 12'(2 * s))}, "trans data");
    end
    go(vslm_pkg::OP_UPACK, 32'h500, 16'h0, 5'h05, 4'h0, 5'h0, 5'h0, 32'h0);
    chk(vecWaddr[0] === 5'h05 && vecWmask[0] === 16'hffff, "upack mask");
    for (int i = 0; i < 8; i++) begin
      chk({vby(0, 2 * i), vby(0, 2 * i + 1)} === {1'b0, mb(12'h500 + 12'(i)), 7'h0}, "upack");
    end
    $display("test slices done");
  endtask

  task automatic t_stall;
    @(posedge ref_clk);
    useValid <= 1'b1;
    useReg <= 5'h06;
    go(vslm_pkg::OP_QUAD, 32'h0, 16'h0, 5'h06, 4'h0, 5'h0, 5'h0, 32'h0);
    chk(vecWe[0] === 1'b1 && stallOut === 1'b0, "load refused");
    @(posedge ref_clk);
    useReg <= 5'h07;
    #1 chk(stallOut === 1'b1, "no stall in first slot");
    @(posedge ref_clk);
    useReg <= 5'h06;
    #1 chk(stallOut === 1'b0, "stall on other register");
    @(posedge ref_clk);
    #1 chk(stallOut === 1'b1, "no stall in third slot");
    @(posedge ref_clk);
    #1 chk(stallOut === 1'b0, "stall after three slots");
    @(posedge ref_clk);
    useValid <= 1'b0;
    $display("test stall done");
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    chk(gprWe === 1'b0 && ctlWe === 1'b0 && vecWe === 8'h0, "strobe in reset");
    rstn <= 1'b1;
    t_scalar();
    t_ctl();
    t_quad();
    t_slices();
    t_stall();
    test_done();
  end
endmodule

//--- tb/vslm_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// Data memory and coprocessor register files
// ****************************************
module vslm_mem_model (
  input  wire logic         ref_clk,
  input  wire logic [11:0]  addr,
  input  wire logic [4:0]   ctlSel,
  input  wire logic [4:0]   vecSel,
  input  wire logic         ctlWe,
  input  wire logic [4:0]   ctlWaddr,
  input  wire logic [31:0]  ctlWdata,
  output logic      [127:0] memLine,
  output logic      [31:0]  ctlData,
  output logic      [127:0] vecData
);
  logic [31:0] ctlReg [32];

  // Byte pattern held at a memory address
  function automatic logic [7:0] mb(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  // Aligned line around the address, byte 0 on top, 4K wrap
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      memLine[127-8*i -: 8] = mb({addr[11:4], 4'(i)});
      vecData[127-8*i -: 8] = {1'b1, vecSel[2:0], 4'(i)};
    end
  end
  assign ctlData = ctlReg[ctlSel];

  // Control registers: preset pattern, written on the strobe edge
  initial for (int i = 0; i < 32; i++) ctlReg[i] = 32'hc0de0000 | 32'(i);
  always @(posedge ref_clk) if (ctlWe) ctlReg[ctlWaddr] <= ctlWdata;
endmodule
